// file: rtl/cmh_can_mode_ctrl.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module cmh_can_mode_ctrl import cmh_pkg::*; #(
	parameter int NUM_TX = 3,
	parameter int WAKE_CYCLES = WAKE_FILTER_CYCLES
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire cmh_avs_req_s avsReq,
	output cmh_avs_rsp_s avsRsp,
	input wire logic canRx,
	input wire cmh_rx_frame_s rxFrame,
	input wire cmh_tx_done_s txDone,
	output logic irq,
	output cmh_mode_s modeStatus
);

	// Window zero is the receive buffer; transmit buffer k sits in window k plus one.
	// All windows share one flat byte array, so reads and writes use one position
	// calculation.
	localparam int NUM_BUF = NUM_TX + 1;
	localparam int MEM_BYTES = NUM_BUF * BUF_BYTES;

	// ==========================================================================
	// Parameter checks.
	// The windows must fit below the top of the index space, and the wake counter
	// is sixteen bits wide, so longer filter times could never be reached.
	initial begin
		if (NUM_TX < 1 || NUM_TX > 13) begin
			$error("NUM_TX must lie between 1 and 13");
		end
		if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin
			$error("WAKE_CYCLES must lie between 1 and 65535");
		end
	end

	// ==========================================================================
	// Whole state of the block in one record.
	// Reset and hold behaviour are written once, in the next-state process, rather
	// than spread over many separate flops.
	typedef struct packed {
		logic [7:0] ctl0;
		logic [7:0] ctl1;
		logic [7:0] btr0;
		logic [7:0] btr1;
		logic [7:0] accCtrl;
		logic [ACC_REGS-1:0][7:0] accCode;
		logic [ACC_REGS-1:0][7:0] accMask;
		logic [IRQ_W-1:0] irqStat;
		logic [IRQ_W-1:0] irqMask;
		logic [MEM_BYTES-1:0][7:0] bufMem;
		logic [15:0] wakeCnt;
		logic [BTR0_PRE_W-1:0] preCnt;
		logic tqTick;
		logic [15:0] stampTimer;
		logic [1:0] rxSync;
		logic ack;
		logic [DATA_W-1:0] readData;
	} cmh_state_s;

	cmh_state_s state_reg;
	cmh_state_s state_next;

	// ==========================================================================
	// Decoding helpers shared by the read and write paths.

	// True when the index falls in one of the message buffer windows.
	// The compare is one bit wider so that the upper bound cannot wrap to zero.
	function automatic logic isBuffer(input logic [7:0] idx);
		logic [4:0] page;
		page = {1'b0, idx[7:4]};
		isBuffer = (page >= {1'b0, BUF_PAGE_RX}) && (page < 5'({1'b0, BUF_PAGE_RX} + 5'(NUM_BUF)));
	endfunction

	// Flat byte position of a buffer location inside the memory array.
	// Callers check the index with isBuffer first; other indices give nonsense.
	function automatic int bufPos(input logic [7:0] idx);
		bufPos = (int'(idx[7:4]) - int'(BUF_PAGE_RX)) * BUF_BYTES + int'(idx[3:0]);
	endfunction

	// Read view of every mapped location; unmapped ones read zero.
	// Reads use only registered state, so a read never sees a write of the same cycle.
	// The receive priority location has no storage and reads zero, and the upper
	// bytes of every word except the timing view read zero.
	function automatic logic [DATA_W-1:0] readWord(input cmh_state_s st, input logic [7:0] idx);
		logic [DATA_W-1:0] w;
		w = '0;
		if (isBuffer(idx)) begin
			if (!(idx[7:4] == BUF_PAGE_RX && idx[3:0] == BUF_PRIORITY)) begin
				w[7:0] = st.bufMem[bufPos(idx)];
			end
		end else if (idx >= IDX_ACC_CODE && idx < IDX_ACC_CODE + 8'(ACC_REGS)) begin
			w[7:0] = st.accCode[idx[2:0]];
		end else if (idx >= IDX_ACC_MASK && idx < IDX_ACC_MASK + 8'(ACC_REGS)) begin
			w[7:0] = st.accMask[idx[2:0]];
		end else begin
			unique case (idx)
				IDX_CTL0: w[7:0] = st.ctl0;
				IDX_CTL1: w[7:0] = st.ctl1;
				IDX_BTR0: w[7:0] = st.btr0;
				IDX_BTR1: w[7:0] = st.btr1;
				IDX_ACC_CTRL: w[7:0] = st.accCtrl;
				IDX_IRQ_STAT: w[IRQ_W-1:0] = st.irqStat;
				IDX_IRQ_MASK: w[IRQ_W-1:0] = st.irqMask;
				IDX_TIMING_VIEW: begin
					w[VIEW_JW_LSB +: 3] = 3'(st.btr0[BTR0_JW_LSB +: BTR0_JW_W]) + 3'h1;
					w[VIEW_DIV_LSB +: 7] = 7'(st.btr0[BTR0_PRE_LSB +: BTR0_PRE_W]) + 7'h01;
				end
				default: w = '0;
			endcase
		end
		readWord = w;
	endfunction

	// ==========================================================================
	// Mode flags seen by the rest of the logic.
	// A request alone changes nothing; each mode needs its acknowledge as well, so
	// software must poll the acknowledge before relying on the mode.
	logic initActive;
	logic sleepActive;
	logic busDominant;
	logic wakeHit;
	logic busReq;
	logic busWrite;
	logic [7:0] busIdx;
	logic [7:0] wByte;

	// Bus decode; a write acts only in the cycle in which waitrequest is low,
	// so a held request is never applied twice.
	assign initActive = state_reg.ctl0[CTL0_INIT_REQ] & state_reg.ctl1[CTL1_INIT_ACK];
	assign sleepActive = state_reg.ctl0[CTL0_SLEEP_REQ] & state_reg.ctl1[CTL1_SLEEP_ACK];
	assign busDominant = ~state_reg.rxSync[1];
	assign busReq = avsReq.read | avsReq.write;
	assign busWrite = avsReq.write & state_reg.ack & avsReq.byteenable[0];
	assign busIdx = avsReq.address[ADDR_W-1:2];
	assign wByte = avsReq.writedata[7:0];

	// With the filter off any dominant sample wakes; with it on the level must hold for the filter time.
	// The compare uses the count before this sample, hence the filter length minus one.
	assign wakeHit = state_reg.ctl1[CTL1_WAKE_FILT] ?
		(busDominant && state_reg.wakeCnt >= 16'(WAKE_CYCLES - 1)) : busDominant;

	// ==========================================================================
	// Next-state logic.
	// Everything except the timestamp counter, which counts up, holds by default; only the strobes below fall back to zero each cycle.
	// Reset is applied last so that it overrides every other update.
	always_comb begin
		logic [IRQ_W-1:0] irqSet;
		logic [IRQ_W-1:0] irqClr;
		int p;
		irqSet = '0;
		irqClr = '0;
		p = 0;
		state_next = state_reg;
		state_next.ack = 1'b0;
		state_next.tqTick = 1'b0;
		state_next.stampTimer = state_reg.stampTimer + 16'h0001;

		// The bus pin passes two flops before anything looks at it.
		state_next.rxSync = {state_reg.rxSync[0], canRx};

		// Quantum clock divides by prescaler field plus one.
		// Greater-or-equal lets a smaller prescaler take effect at once instead of
		// waiting for the counter to wrap through its whole range.
		if (state_reg.preCnt >= state_reg.btr0[BTR0_PRE_LSB +: BTR0_PRE_W]) begin
			state_next.preCnt = '0;
			state_next.tqTick = 1'b1;
		end else begin
			state_next.preCnt = state_reg.preCnt + 6'h01;
		end

		// One wait state: the read word is captured now and shown while waitrequest is low.
		if (busReq && !state_reg.ack) begin
			state_next.ack = 1'b1;
			state_next.readData = readWord(state_reg, busIdx);
		end

		// Writes land on the edge where waitrequest is sampled low.
		// Read-only and protected locations drop writes silently; there is no error
		// response, so software has to read back to see whether a write took.
		if (busWrite) begin
			if (isBuffer(busIdx)) begin
				p = bufPos(busIdx);
				if (busIdx[3:0] != BUF_STAMP_HI && busIdx[3:0] != BUF_STAMP_LO &&
					!(busIdx[7:4] == BUF_PAGE_RX && busIdx[3:0] == BUF_PRIORITY)) begin
					state_next.bufMem[p] = wByte;
				end
			end else if (busIdx >= IDX_ACC_CODE && busIdx < IDX_ACC_CODE + 8'(ACC_REGS)) begin
				if (initActive) begin
					state_next.accCode[busIdx[2:0]] = wByte;
				end
			end else if (busIdx >= IDX_ACC_MASK && busIdx < IDX_ACC_MASK + 8'(ACC_REGS)) begin
				if (initActive) begin
					state_next.accMask[busIdx[2:0]] = wByte;
				end
			end else begin
				unique case (busIdx)
					IDX_CTL0: state_next.ctl0 = wByte & CTL0_WR_MASK;
					IDX_CTL1: begin
						if (initActive) begin
							state_next.ctl1[7:2] = wByte[7:2];
						end
					end
					IDX_BTR0: begin
						if (initActive) begin
							state_next.btr0 = wByte;
						end
					end
					IDX_BTR1: begin
						if (initActive) begin
							state_next.btr1 = wByte;
						end
					end
					IDX_ACC_CTRL: begin
						if (initActive) begin
							state_next.accCtrl = wByte;
						end
					end
					IDX_IRQ_STAT: irqClr = wByte[IRQ_W-1:0];
					IDX_IRQ_MASK: state_next.irqMask = wByte[IRQ_W-1:0];
					default: state_next.ctl0 = state_next.ctl0;
				endcase
			end
		end

		// Init acknowledge follows the request one cycle later.
		// The lag makes the handshake visible to software, and the acknowledge
		// falls in the same way when the request is withdrawn.
		state_next.ctl1[CTL1_INIT_ACK] = state_reg.ctl0[CTL0_INIT_REQ];

		// Sleep acknowledge answers the request and drops when it is withdrawn.
		// A wake further down overrides this for the cycle in which it happens.
		state_next.ctl1[CTL1_SLEEP_ACK] = state_reg.ctl0[CTL0_SLEEP_REQ];

		// Dominant run length seen while asleep feeds the wake filter.
		// The count saturates, so a bus stuck dominant cannot wrap it back below the
		// filter length and lose a pending wake.
		if (sleepActive && busDominant) begin
			if (state_reg.wakeCnt != 16'hFFFF) begin
				state_next.wakeCnt = state_reg.wakeCnt + 16'h0001;
			end
		end else begin
			state_next.wakeCnt = '0;
		end

		// Wake beats any request written in the same cycle, so the block is never left half asleep.
		// The wake also clears the request, otherwise the acknowledge would simply
		// be raised again on the next clock.
		if (sleepActive && state_reg.ctl0[CTL0_WAKE_EN] && wakeHit) begin
			state_next.ctl0[CTL0_SLEEP_REQ] = 1'b0;
			state_next.ctl1[CTL1_SLEEP_ACK] = 1'b0;
			state_next.wakeCnt = '0;
			irqSet[IRQ_WAKE] = 1'b1;
		end

		// A received frame fills the receive buffer in the shared layout and stamps it.
		// There is no check that software has read the previous frame; a new frame
		// overwrites it, and nothing tells software that it happened; the receive event bit is set for every frame.
		if (rxFrame.valid) begin
			for (int i = 0; i < FRAME_BYTES; i++) begin
				state_next.bufMem[i] = rxFrame.bytes[i];
			end
			state_next.bufMem[int'(BUF_STAMP_HI)] = state_reg.stampTimer[15:8];
			state_next.bufMem[int'(BUF_STAMP_LO)] = state_reg.stampTimer[7:0];
			irqSet[IRQ_RX] = 1'b1;
		end

		// A finished transmission stamps its buffer; out of range indices are dropped.
		// Transmit buffer k lives in window k plus one, behind the receive buffer.
		if (txDone.valid && int'(txDone.index) < NUM_TX) begin
			p = (int'(txDone.index) + 1) * BUF_BYTES;
			state_next.bufMem[p + int'(BUF_STAMP_HI)] = state_reg.stampTimer[15:8];
			state_next.bufMem[p + int'(BUF_STAMP_LO)] = state_reg.stampTimer[7:0];
		end

		// Sticky events: a new event in the clearing cycle survives.
		// Writing a one clears a bit; writing a zero leaves it alone.
		state_next.irqStat = (state_reg.irqStat & ~irqClr) | irqSet;

		// Reset leaves the buffer RAM alone except the transmit priority bytes.
		// The buffer RAM has no reset of its own, so its contents survive reset; the
		// priority bytes are the one exception and are forced to zero here.
		if (srst) begin
			state_next.ctl0 = CTL0_RST;
			state_next.ctl1 = CTL1_RST;
			state_next.btr0 = BTR0_RST;
			state_next.btr1 = BTR1_RST;
			state_next.accCtrl = '0;
			state_next.accCode = '0;
			state_next.accMask = '0;
			state_next.irqStat = '0;
			state_next.irqMask = '0;
			state_next.wakeCnt = '0;
			state_next.preCnt = '0;
			state_next.tqTick = 1'b0;
			state_next.stampTimer = '0;
			state_next.rxSync = 2'h3;
			state_next.ack = 1'b0;
			state_next.readData = '0;
			state_next.bufMem = state_reg.bufMem;
			for (int t = 1; t < NUM_BUF; t++) begin
				state_next.bufMem[t * BUF_BYTES + int'(BUF_PRIORITY)] = PRIORITY_RST;
			end
		end
	end

	// ==========================================================================
	// State register.
	// There is no asynchronous reset; srst is folded into the next-state logic,
	// which keeps every flop on the same plain clocked path.
	always_ff @(posedge clk_sys) begin
		state_reg <= state_next;
	end

	// ==========================================================================
	// Outputs.

	// Bus response; waitrequest is combinational so the single wait state costs nothing extra.
	assign avsRsp.readdata = state_reg.readData;
	assign avsRsp.waitrequest = busReq & ~state_reg.ack;

	// Level interrupt, high while any unmasked event is pending.
	assign irq = |(state_reg.irqStat & state_reg.irqMask);

	// Mode and timing view for the frame engine.
	assign modeStatus.initActive = initActive;
	assign modeStatus.sleepActive = sleepActive;
	assign modeStatus.quantumTick = state_reg.tqTick;
	assign modeStatus.jumpWidthTq = 3'(state_reg.btr0[BTR0_JW_LSB +: BTR0_JW_W]) + 3'h1;
	assign modeStatus.quantumDivisor = 7'(state_reg.btr0[BTR0_PRE_LSB +: BTR0_PRE_W]) + 7'h01;

endmodule

// file: inc/cmh_pkg.sv
package cmh_pkg;

	// ==========================================================================
	// Bus geometry and register indices (byte address = 4 * index).
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam logic [7:0] IDX_CTL0 = 8'h00;
	localparam logic [7:0] IDX_CTL1 = 8'h01;
	localparam logic [7:0] IDX_BTR0 = 8'h02;
	localparam logic [7:0] IDX_BTR1 = 8'h03;
	localparam logic [7:0] IDX_ACC_CTRL = 8'h04;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h05;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h06;
	localparam logic [7:0] IDX_TIMING_VIEW = 8'h07;
	localparam logic [7:0] IDX_ACC_CODE = 8'h08;
	localparam logic [7:0] IDX_ACC_MASK = 8'h10;
	localparam logic [3:0] BUF_PAGE_RX = 4'h2;
	localparam int ACC_REGS = 8;

	// ==========================================================================
	// Field positions.
	localparam int CTL0_INIT_REQ = 0;
	localparam int CTL0_SLEEP_REQ = 1;
	localparam int CTL0_WAKE_EN = 2;
	localparam logic [7:0] CTL0_WR_MASK = 8'h07;
	localparam int CTL1_INIT_ACK = 0;
	localparam int CTL1_SLEEP_ACK = 1;
	localparam int CTL1_WAKE_FILT = 2;
	localparam int BTR0_JW_LSB = 6;
	localparam int BTR0_JW_W = 2;
	localparam int BTR0_PRE_LSB = 0;
	localparam int BTR0_PRE_W = 6;
	localparam int IRQ_WAKE = 0;
	localparam int IRQ_RX = 1;
	localparam int IRQ_W = 2;
	localparam int VIEW_JW_LSB = 0;
	localparam int VIEW_DIV_LSB = 8;

	// ==========================================================================
	// Message buffer layout, one 16-byte window per buffer.
	localparam int BUF_BYTES = 16;
	localparam int FRAME_BYTES = 13;
	localparam logic [3:0] BUF_IDENT = 4'h0;
	localparam logic [3:0] BUF_PAYLOAD = 4'h4;
	localparam logic [3:0] BUF_LENGTH = 4'hC;
	localparam logic [3:0] BUF_PRIORITY = 4'hD;
	localparam logic [3:0] BUF_STAMP_HI = 4'hE;
	localparam logic [3:0] BUF_STAMP_LO = 4'hF;

	// ==========================================================================
	// Reset values.
	localparam logic [7:0] CTL0_RST = 8'h00;
	localparam logic [7:0] CTL1_RST = 8'h00;
	localparam logic [7:0] BTR0_RST = 8'h00;
	localparam logic [7:0] BTR1_RST = 8'h00;
	localparam logic [7:0] PRIORITY_RST = 8'h00;

	// ==========================================================================
	// Timing: wake filter time turned into clock cycles, rounded up.
	localparam int CLK_KHZ = 10000;
	localparam int WAKE_FILTER_NS = 2000;
	localparam int WAKE_FILTER_CYCLES_RAW = (WAKE_FILTER_NS * CLK_KHZ + 999999) / 1000000;
	localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_CYCLES_RAW < 1) ? 1 : WAKE_FILTER_CYCLES_RAW;

	// ==========================================================================
	// Carriers.
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [3:0] byteenable;
	} cmh_avs_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] readdata;
		logic waitrequest;
	} cmh_avs_rsp_s;

	typedef struct packed {
		logic valid;
		logic [FRAME_BYTES-1:0][7:0] bytes;
	} cmh_rx_frame_s;

	typedef struct packed {
		logic valid;
		logic [3:0] index;
	} cmh_tx_done_s;

	typedef struct packed {
		logic initActive;
		logic sleepActive;
		logic quantumTick;
		logic [2:0] jumpWidthTq;
		logic [6:0] quantumDivisor;
	} cmh_mode_s;

endpackage

// file: testbench/cmh_bus_node.sv
`timescale 1ns/1ps
// ==========================================================================
// Remote node that holds the bus dominant for a chosen number of clocks.
module cmh_bus_node (
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [7:0] domLen,
	output logic canRx
);
	logic [7:0] left = 8'h00;
	// Load the pulse length on a request, then count it away.
	always @(posedge clk_sys) begin
		if (go) begin
			left <= domLen;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
	end
	// The bus idles recessive through its pull-up once the node lets go.
	assign canRx = (left == 8'h00);
endmodule

// file: testbench/cmh_can_mode_ctrl_monitor.sv
`timescale 1ns/1ps
// ==========================================================================
// Checker on the register bus, mode flags and timing outputs.
module cmh_can_mode_ctrl_monitor import cmh_pkg::*; #(
	parameter int NUM_TX = 3,
	parameter int WAKE_CYCLES = 4
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire cmh_avs_req_s avsReq,
	input wire cmh_avs_rsp_s avsRsp,
	input wire logic canRx,
	input wire cmh_rx_frame_s rxFrame,
	input wire cmh_tx_done_s txDone,
	input wire logic irq,
	input wire cmh_mode_s modeStatus
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic req;
	// A request is either direction of access.
	assign req = avsReq.read | avsReq.write;
	AST_WAIT_ONE: assert property ($rose(req) |-> avsRsp.waitrequest ##1 !avsRsp.waitrequest)
		else $error("access not answered after one wait cycle");
	AST_IDLE_NOWAIT: assert property (!req |-> !avsRsp.waitrequest)
		else $error("waitrequest high without a request");
	AST_RESET_STATE: assert property ($fell(srst) |-> !irq && !modeStatus.initActive &&
		!modeStatus.sleepActive && modeStatus.jumpWidthTq == 3'd1 && modeStatus.quantumDivisor == 7'd1)
		else $error("state after reset is wrong");
	AST_FIELD_RANGE: assert property (modeStatus.jumpWidthTq inside {[1:4]} &&
		modeStatus.quantumDivisor inside {[1:64]})
		else $error("jump width or divisor out of range");
	AST_TICK_SPACING: assert property (modeStatus.quantumTick && modeStatus.quantumDivisor > 7'd1
		|=> !modeStatus.quantumTick || $changed(modeStatus.quantumDivisor))
		else $error("quantum ticks too close");
	AST_TICK_DIV1: assert property (modeStatus.quantumDivisor == 7'd1 && $past(modeStatus.quantumDivisor) == 7'd1
		&& $past(modeStatus.quantumDivisor, 2) == 7'd1 && !$past(srst) && !$past(srst, 2) |-> modeStatus.quantumTick)
		else $error("no tick at divisor one");
	AST_INIT_CAUSE: assert property ($rose(modeStatus.initActive) |-> $past(avsReq.write) ||
		$past(avsReq.write, 2) || $past(avsReq.write, 3) || $past(avsReq.write, 4))
		else $error("init mode entered without a write");
	AST_SLEEP_CAUSE: assert property ($rose(modeStatus.sleepActive) |-> $past(avsReq.write) ||
		$past(avsReq.write, 2) || $past(avsReq.write, 3) || $past(avsReq.write, 4))
		else $error("sleep entered without a write");
	AST_WAKE_CAUSE: assert property ($fell(modeStatus.sleepActive) && !$past(avsReq.write) &&
		!$past(avsReq.write, 2) |-> !$past(canRx) || !$past(canRx, 2) || !$past(canRx, 3) ||
		!$past(canRx, 4) || !$past(canRx, 5))
		else $error("sleep left without bus activity");
endmodule

bind cmh_can_mode_ctrl cmh_can_mode_ctrl_monitor #(.NUM_TX(NUM_TX), .WAKE_CYCLES(WAKE_CYCLES)) u_mon (
	.clk_sys(clk_sys), .srst(srst), .avsReq(avsReq), .avsRsp(avsRsp), .canRx(canRx),
	.rxFrame(rxFrame), .txDone(txDone), .irq(irq), .modeStatus(modeStatus));

// file: testbench/tb_can_mode_handshake_timing_buffers.sv
`timescale 1ns/1ps
// ==========================================================================
// Register-level bench for the mode handshakes, timing and buffers.
module tb_can_mode_handshake_timing_buffers import cmh_pkg::*; ();
	localparam logic [7:0] BT [3] = '{8'h3F, 8'hC0, 8'h02};
	localparam logic [15:0] VW [3] = '{16'h4001, 16'h0104, 16'h0301};
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	cmh_avs_req_s avsReq = '0;
	cmh_avs_rsp_s avsRsp;
	cmh_rx_frame_s rxFrame = '0;
	cmh_tx_done_s txDone = '0;
	cmh_mode_s modeStatus;
	logic canRx;
	logic irq;
	logic nodeGo = 1'b0;
	logic [7:0] nodeLen = 8'h00;
	logic [15:0] rdVal;
	int miscompares = 0;
	int nCompared = 0;
	int gap;
	logic [15:0] stampRef;
	logic [15:0] txStamp;
	cmh_can_mode_ctrl #(.NUM_TX(3), .WAKE_CYCLES(4)) dut (.clk_sys(clk_sys), .srst(srst), .avsReq(avsReq),
		.avsRsp(avsRsp), .canRx(canRx), .rxFrame(rxFrame), .txDone(txDone), .irq(irq), .modeStatus(modeStatus));
	cmh_bus_node node (.clk_sys(clk_sys), .go(nodeGo), .domLen(nodeLen), .canRx(canRx));
	// Reference for the free-running timestamp counter, cleared by reset.
	always @(posedge clk_sys) stampRef <= srst ? 16'h0000 : stampRef + 16'h0001;
	// Free-running 10 MHz clock.
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	// ==========================================================================
	// Bus tasks; waitrequest and read data are taken at the rising edge, before the flops move.
	task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		avsReq <= '{read: !w, write: w, address: {idx, 2'b00}, writedata: {24'h000000, d}, byteenable: 4'hF};
		@(posedge clk_sys);
		while (avsRsp.waitrequest !== 1'b0 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		if (avsRsp.waitrequest !== 1'b0) begin
			miscompares++;
			$display("mismatch waitrequest expected 0 seen %b", avsRsp.waitrequest);
		end
		q = avsRsp.readdata[15:0];
		avsReq <= '0;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		nCompared++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [15:0] q;
		acc(1'b1, idx, d, q);
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [15:0] e);
		logic [15:0] q;
		acc(1'b0, idx, 8'h00, q);
		chk(nm, e, q);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic pulse(input logic [7:0] len);
		@(posedge clk_sys);
		nodeLen <= len;
		nodeGo <= 1'b1;
		@(posedge clk_sys);
		nodeGo <= 1'b0;
	endtask
	task automatic doReset();
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
	endtask
	task automatic prioZero();
		for (int k = 0; k < 3; k++) rdc("txPriority", 8'h3D + 8'(16 * k), 16'h0000);
	endtask
	// Protected registers: timing, acceptance control, codes and masks.
	task automatic sweep(input logic [7:0] d, input logic [7:0] e, input logic z);
		logic [7:0] idx;
		for (int i = 0; i < 19; i++) begin
			idx = (i < 3) ? IDX_BTR0 + 8'(i) : IDX_ACC_CODE + 8'(i - 3);
			wr(idx, d ^ 8'(i));
			rdc("protected", idx, z ? 16'h0000 : 16'(e ^ 8'(i)));
		end
	endtask
	task automatic tickGap(output int g);
		int n;
		n = 0;
		while (modeStatus.quantumTick !== 1'b1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
		g = 1;
		while (modeStatus.quantumTick !== 1'b1 && g < 200) begin
			@(negedge clk_sys);
			g++;
		end
	endtask
	task automatic printVerdict();
		if (miscompares == 0 && nCompared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================================
	// Main sequence.
	initial begin
		doReset();
		rdc("btr0", IDX_BTR0, 16'h0000);
		prioZero();
		wr(IDX_CTL1, 8'hFC);
		rdc("ctl1", IDX_CTL1, 16'h0000);
		sweep(8'h5A, 8'h00, 1'b1);
		wr(IDX_IRQ_MASK, 8'h03);
		wr(IDX_CTL0, 8'h01);
		rdc("ctl1", IDX_CTL1, 16'h0001);
		idle(1);
		chk("initActive", 16'h0001, 16'(modeStatus.initActive));
		sweep(8'hA5, 8'hA5, 1'b0);
		idle(1);
		chk("jumpWidth", 16'h0003, 16'(modeStatus.jumpWidthTq));
		chk("divisor", 16'h0026, 16'(modeStatus.quantumDivisor));
		wr(IDX_CTL0, 8'h00);
		rdc("ctl1", IDX_CTL1, 16'h0000);
		sweep(8'h5A, 8'hA5, 1'b0);
		wr(IDX_CTL0, 8'h01);
		rdc("ctl1", IDX_CTL1, 16'h0001);
		// Field boundaries, ending on a divisor of three for the tick spacing.
		for (int i = 0; i < 3; i++) begin
			wr(IDX_BTR0, BT[i]);
			rdc("timingView", IDX_TIMING_VIEW, VW[i]);
		end
		idle(1);
		tickGap(gap);
		chk("tickGap", 16'h0003, 16'(gap));
		wr(IDX_CTL1, 8'h04);
		rdc("ctl1", IDX_CTL1, 16'h0005);
		// Filtered wake: a short glitch must not wake, a long pulse must.
		wr(IDX_CTL0, 8'h06);
		rdc("ctl1", IDX_CTL1, 16'h0006);
		idle(1);
		chk("sleepActive", 16'h0001, 16'(modeStatus.sleepActive));
		pulse(8'd2);
		idle(12);
		chk("sleepActive", 16'h0001, 16'(modeStatus.sleepActive));
		pulse(8'd8);
		idle(16);
		chk("sleepActive", 16'h0000, 16'(modeStatus.sleepActive));
		chk("irq", 16'h0001, 16'(irq));
		rdc("ctl0", IDX_CTL0, 16'h0004);
		rdc("ctl1", IDX_CTL1, 16'h0004);
		rdc("irqStat", IDX_IRQ_STAT, 16'h0001);
		wr(IDX_IRQ_STAT, 8'h01);
		idle(1);
		chk("irq", 16'h0000, 16'(irq));
		// Unfiltered wake on a single dominant clock.
		wr(IDX_CTL0, 8'h01);
		rdc("ctl1", IDX_CTL1, 16'h0005);
		wr(IDX_CTL1, 8'h00);
		wr(IDX_CTL0, 8'h06);
		rdc("ctl1", IDX_CTL1, 16'h0002);
		pulse(8'd1);
		idle(12);
		chk("sleepActive", 16'h0000, 16'(modeStatus.sleepActive));
		wr(IDX_IRQ_STAT, 8'h01);
		// Without wake enable the bus is ignored while asleep.
		wr(IDX_CTL0, 8'h02);
		rdc("ctl1", IDX_CTL1, 16'h0002);
		pulse(8'd8);
		idle(16);
		chk("sleepActive", 16'h0001, 16'(modeStatus.sleepActive));
		wr(IDX_CTL0, 8'h00);
		idle(1);
		chk("irq", 16'h0000, 16'(irq));
		// Received frame lands in the receive window.
		@(posedge clk_sys);
		rxFrame.valid <= 1'b1;
		for (int i = 0; i < 13; i++) rxFrame.bytes[i] <= 8'h31 + 8'(i);
		@(posedge clk_sys);
		rxFrame.valid <= 1'b0;
		idle(2);
		chk("irq", 16'h0001, 16'(irq));
		for (int i = 0; i < 13; i++) rdc("rxByte", 8'h20 + 8'(i), 16'(8'h31 + 8'(i)));
		rdc("rxPriority", 8'h2D, 16'h0000);
		wr(8'h2D, 8'h77);
		rdc("rxPriority", 8'h2D, 16'h0000);
		acc(1'b0, 8'h2E, 8'h00, rdVal);
		wr(8'h2E, ~rdVal[7:0]);
		rdc("stamp", 8'h2E, rdVal);
		// Transmit buffer one, priority byte included.
		for (int i = 0; i < 14; i++) begin
			wr(8'h40 + 8'(i), 8'hC0 + 8'(i));
			rdc("txByte", 8'h40 + 8'(i), 16'(8'hC0 + 8'(i)));
		end
		@(posedge clk_sys);
		txDone <= '{valid: 1'b1, index: 4'h1};
		@(posedge clk_sys);
		txDone <= '0;
		txStamp = stampRef;
		rdc("txStampHi", 8'h4E, 16'(txStamp[15:8]));
		rdc("txStampLo", 8'h4F, 16'(txStamp[7:0]));
		rdc("unmapped", 8'h18, 16'h0000);
		// A second reset clears the priority bytes of every transmit buffer.
		doReset();
		prioZero();
		rdc("btr0", IDX_BTR0, 16'h0000);
		printVerdict();
	end
	// Watchdog at 10000 cycles, well beyond the fewer than a thousand cycles the sequence needs.
	initial begin
		#1000000;
		miscompares++;
		$display("mismatch watchdog expected finish seen timeout");
		printVerdict();
	end
endmodule
